// ===== mu_status_unit.sv
// Host port, argument window and completion reporting of the math unit.
// Operation
// - Flag byte read at I/O base plus seven, always current.
// - Status byte read at I/O base plus one after completion.
// - Status bits 7,6,5 hold equal, greater, less; bits 4,3 read zero.
// - Status low three bits hold the error code.
// - Zero divisor on fixed, extended or float divide reports code 001.
// - Negative argument to square root reports code 010.
// - Float exponent overflow or conversion overflow reports code 011.
// - Float-to-fixed overflow leaves the float argument unchanged.
// - Exponent overflow subtracts 0BE hex, keeps low eight bits.
// - Exponent underflow reports 100, adds 0BE hex, keeps low eight bits.
// - Invalid first argument reports 101; second not checked.
// - Invalid first argument stays unmodified in the window.
// - Invalid second argument reports 110, checked after the first.
// - Memory base holds until reprogrammed; no reload per operation.
// - Opcode write to the I/O base starts that operation.
// - Two distinct completion events: clean and with error.
// - Both completion outputs may share or split interrupt lines.
module mu_status_unit (
    input wire logic clk,
    input wire logic rst,
    input wire mu_pkg::mu_io_s io,
    output logic [7:0] io_rdata,
    input wire mu_pkg::mu_mem_s mem,
    output logic [7:0] mem_rdata,
    output logic mem_ack,
    input wire mu_pkg::mu_eng_s eng,
    output logic eng_start,
    output logic [3:0] eng_op,
    output logic [31:0] eng_a,
    output logic [31:0] eng_b,
    output logic done_ok,
    output logic done_err
);
    typedef enum logic [1:0] {
        MU_IDLE = 2'b00,
        MU_CHECK = 2'b01,
        MU_RUN = 2'b10
    } mu_state_e;

    mu_state_e state_q;
    mu_state_e state_d;
    logic [7:0] win_q [mu_pkg::WIN_DEPTH];
    logic [7:0] base_lo_q;
    logic [15:0] base_q;
    logic base_ok_q;
    logic [3:0] op_q;
    logic busy_q;
    logic flag_ok_q;
    logic flag_err_q;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic finish;
    logic [2:0] fin_err;
    mu_pkg::mu_chk_s chk;
    logic [31:0] arg1_w;
    logic [31:0] arg2_w;
    logic io_free;
    logic op_wr;
    logic mem_hit;
    logic wrap_op;
    logic eng_ovf;
    logic eng_unf;
    logic [9:0] exp_adj;
    logic [31:0] wb_val;
    logic wb_en;
    logic [2:0] eng_err;
    logic [7:0] flag_byte;
    logic [7:0] rd_byte;
    logic [7:0] wb_exp;

    // Little-endian argument words from the window.
    assign arg1_w = {win_q[3], win_q[2], win_q[1], win_q[0]};
    assign arg2_w = {win_q[7], win_q[6], win_q[5], win_q[4]};
    assign wb_exp = {win_q[3][6:0], win_q[2][7]};

    mu_arg_check u_check (
        .op(op_q),
        .arg_a(arg1_w),
        .arg_b(arg2_w),
        .chk(chk)
    );

    // Host request decode; while busy only flag reads are honoured.
    assign io_free = !busy_q;
    assign op_wr = io.wr && io_free && io.addr == mu_pkg::IO_OPCODE;
    assign mem_hit = base_ok_q && io_free &&
        mem.addr[15:4] == base_q[15:4];

    // Float add, subtract, multiply, divide and square results get exponent wraparound; square root and conversions do not.
    assign wrap_op = op_q == mu_pkg::float_add_op ||
        op_q == mu_pkg::float_subtract_op ||
        op_q == mu_pkg::float_multiply_op ||
        op_q == mu_pkg::float_divide_op ||
        op_q == mu_pkg::float_square_op;
    assign eng_ovf = wrap_op && !eng.zero &&
        $signed(eng.exp) > mu_pkg::EXP_MAX;
    assign eng_unf = wrap_op && !eng.zero &&
        $signed(eng.exp) < mu_pkg::EXP_MIN;
    assign exp_adj = eng_ovf ? eng.exp - mu_pkg::EXP_WRAP :
        eng_unf ? eng.exp + mu_pkg::EXP_WRAP : eng.exp;
    assign wb_val = wrap_op ?
        {eng.value[31], exp_adj[7:0], eng.value[22:0]} : eng.value;

    // A conversion overflow keeps the float argument, so no writeback.
    assign eng_err = (op_q == mu_pkg::float_to_fixed_op && eng.fix_ovf) ?
        mu_pkg::ERR_OVF :
        eng_ovf ? mu_pkg::ERR_OVF : eng_unf ? mu_pkg::ERR_UNF :
        mu_pkg::ERR_NONE;
    assign wb_en = state_q == MU_RUN && eng.done &&
        !(op_q == mu_pkg::float_to_fixed_op && eng.fix_ovf);

    // Sequencer: screen arguments, then hand off to the engine if clean and not a compare, zero test or exchange.
    always_comb begin
        state_d = state_q;
        finish = 1'b0;
        fin_err = mu_pkg::ERR_NONE;
        unique case (state_q)
            MU_IDLE: begin
                if (op_wr) begin
                    state_d = MU_CHECK;
                end
            end
            MU_CHECK: begin
                if (chk.use_eng) begin
                    state_d = MU_RUN;
                end else begin
                    state_d = MU_IDLE;
                    finish = 1'b1;
                    fin_err = chk.err;
                end
            end
            MU_RUN: begin
                if (eng.done) begin
                    state_d = MU_IDLE;
                    finish = 1'b1;
                    fin_err = eng_err;
                end
            end
            default: begin
                state_d = MU_IDLE;
            end
        endcase
    end

    // Relation bits come only from the screening step; reserved bits zero.
    assign status_d = {chk.eq, chk.gt, chk.lt, 2'b00, fin_err};

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= MU_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Busy, completion flags and status; flags clear at the next start.
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q <= 1'b0;
            flag_ok_q <= 1'b0;
            flag_err_q <= 1'b0;
            status_q <= 8'h00;
            op_q <= 4'h0;
        end else if (op_wr) begin
            busy_q <= 1'b1;
            flag_ok_q <= 1'b0;
            flag_err_q <= 1'b0;
            op_q <= io.data[3:0];
        end else if (finish) begin
            busy_q <= 1'b0;
            flag_ok_q <= fin_err == mu_pkg::ERR_NONE;
            flag_err_q <= fin_err != mu_pkg::ERR_NONE;
            status_q <= status_d;
        end
    end

    // One pulse per operation on exactly one of the two completion lines.
    always_ff @(posedge clk) begin
        if (rst) begin
            done_ok <= 1'b0;
            done_err <= 1'b0;
        end else begin
            done_ok <= finish && fin_err == mu_pkg::ERR_NONE;
            done_err <= finish && fin_err != mu_pkg::ERR_NONE;
        end
    end

    // Memory base, loaded low byte then high byte; the low nibble is
    // forced to zero so the sixteen-byte window stays aligned.
    always_ff @(posedge clk) begin
        if (rst) begin
            base_lo_q <= 8'h00;
            base_q <= 16'h0000;
            base_ok_q <= 1'b0;
        end else if (io.wr && io_free) begin
            if (io.addr == mu_pkg::IO_MEM_LOW) begin
                base_lo_q <= io.data;
            end else if (io.addr == mu_pkg::IO_MEM_HIGH) begin
                base_q <= {io.data, base_lo_q[7:4], mu_pkg::WIN_ZERO};
                base_ok_q <= 1'b1;
            end
        end
    end

    // I/O read data; status reads during busy are ignored and give zero.
    assign flag_byte = {5'h00, flag_err_q, flag_ok_q, busy_q};
    assign rd_byte = (io.addr == mu_pkg::IO_FLAG) ? flag_byte :
        (io.addr == mu_pkg::IO_STATUS && io_free) ? status_q :
        8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            io_rdata <= 8'h00;
        end else begin
            io_rdata <= io.rd ? rd_byte : 8'h00;
        end
    end

    // Host window reads; no acknowledge while busy, so the host waits.
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_ack <= 1'b0;
            mem_rdata <= 8'h00;
        end else begin
            mem_ack <= mem_hit && (mem.rd || mem.wr);
            mem_rdata <= (mem_hit && mem.rd) ? win_q[mem.addr[3:0]] : 8'h00;
        end
    end

    // Engine launch carries a snapshot of both arguments.
    always_ff @(posedge clk) begin
        if (rst) begin
            eng_start <= 1'b0;
            eng_op <= 4'h0;
            eng_a <= 32'h0;
            eng_b <= 32'h0;
        end else begin
            eng_start <= state_q == MU_CHECK && chk.use_eng;
            if (state_q == MU_CHECK) begin
                eng_op <= op_q;
                eng_a <= arg1_w;
                eng_b <= arg2_w;
            end
        end
    end

    // Argument window: host writes when idle, exchange, result writeback.
    // Screening error exits and conversion overflow never write, which is what keeps bad arguments readable.
    always_ff @(posedge clk) begin
        if (mem_hit && mem.wr) begin
            win_q[mem.addr[3:0]] <= mem.data;
        end else if (state_q == MU_CHECK && chk.exch) begin
            for (int i = 0; i < 4; i++) begin
                win_q[i] <= win_q[i + 4];
                win_q[i + 4] <= win_q[i];
            end
        end else if (wb_en) begin
            for (int i = 0; i < 4; i++) begin
                win_q[i] <= wb_val[8 * i +: 8];
            end
        end
    end

    // Flag reads return the live flag byte one cycle later.
    flag_read_a: assert property (@(posedge clk) disable iff (rst)
        io.rd && io.addr == mu_pkg::IO_FLAG |=>
        io_rdata == {5'h00, $past(flag_err_q), $past(flag_ok_q),
        $past(busy_q)})
        else $error("flag byte read mismatch");

    // Idle status reads return the stored status, reserved bits zero.
    status_read_a: assert property (@(posedge clk) disable iff (rst)
        io.rd && io.addr == mu_pkg::IO_STATUS && !busy_q |=>
        io_rdata == $past(status_q) && io_rdata[4:3] == 2'b00)
        else $error("status byte read mismatch");

    // At most one relation bit, and none alongside an error.
    relation_bits_a: assert property (@(posedge clk) disable iff (rst)
        $onehot0(status_q[7:5]) &&
        (status_q[2:0] == mu_pkg::ERR_NONE || status_q[7:5] == 3'b000))
        else $error("relation bits inconsistent");

    // A screening error ends the operation with that code and error pulse.
    screen_error_a: assert property (@(posedge clk) disable iff (rst)
        state_q == MU_CHECK && chk.err != mu_pkg::ERR_NONE |=>
        status_q[2:0] == $past(chk.err) && done_err && !busy_q && !eng_start)
        else $error("screening error not reported");

    // Overflow wraps the stored exponent down by 0BE hex.
    overflow_wrap_a: assert property (@(posedge clk) disable iff (rst)
        state_q == MU_RUN && eng.done && eng_ovf |=>
        wb_exp == 8'($past(eng.exp) - mu_pkg::EXP_WRAP) &&
        status_q[2:0] == mu_pkg::ERR_OVF)
        else $error("overflow wraparound wrong");

    // Underflow wraps the stored exponent up by 0BE hex.
    under_wrap_a: assert property (@(posedge clk) disable iff (rst)
        state_q == MU_RUN && eng.done && eng_unf |=>
        wb_exp == 8'($past(eng.exp) + mu_pkg::EXP_WRAP) &&
        status_q[2:0] == mu_pkg::ERR_UNF && done_err)
        else $error("underflow wraparound wrong");

    // Conversion overflow leaves the float argument in place.
    fix_keep_a: assert property (@(posedge clk) disable iff (rst)
        state_q == MU_RUN && eng.done && eng.fix_ovf &&
        op_q == mu_pkg::float_to_fixed_op |=> $stable(arg1_w) && done_err)
        else $error("float argument changed on overflow");

    // A bad first argument to a compare is not touched and hides the second.
    arg1_keep_a: assert property (@(posedge clk) disable iff (rst)
        state_q == MU_CHECK && mu_pkg::float_invalid(arg1_w) &&
        op_q == mu_pkg::float_compare_op |=>
        $stable(arg1_w) && status_q[2:0] == mu_pkg::ERR_ARG1)
        else $error("first argument error handling wrong");

    // Busy blocks base and opcode writes and window reads.
    busy_ignore_a: assert property (@(posedge clk) disable iff (rst)
        busy_q && (io.wr || mem.rd) |=>
        $stable(base_q) && $stable(op_q) && !mem_ack)
        else $error("request taken while busy");

    // Busy drops together with exactly one completion pulse.
    one_done_a: assert property (@(posedge clk) disable iff (rst)
        $fell(busy_q) |-> (done_ok ^ done_err) ##1 !done_ok && !done_err)
        else $error("completion pulse count wrong");

    // A clean engine finish raises only the clean completion line.
    clean_done_a: assert property (@(posedge clk) disable iff (rst)
        state_q == MU_RUN && eng.done && eng_err == mu_pkg::ERR_NONE |=>
        done_ok && !done_err && flag_ok_q && !busy_q)
        else $error("clean completion not signalled");

    // An opcode write while idle starts the operation.
    start_a: assert property (@(posedge clk) disable iff (rst)
        io.wr && io.addr == mu_pkg::IO_OPCODE && !busy_q |=>
        busy_q && op_q == $past(io.data[3:0]) && !done_ok && !done_err)
        else $error("operation did not start");
endmodule

// ===== mu_pkg.sv
// Shared constants, opcodes and carriers of the math unit status logic.
package mu_pkg;
    // I/O port offsets from the switch-selected I/O base.
    localparam logic [2:0] IO_OPCODE = 3'h0;
    localparam logic [2:0] IO_STATUS = 3'h1;
    localparam logic [2:0] IO_MEM_LOW = 3'h1;
    localparam logic [2:0] IO_MEM_HIGH = 3'h2;
    localparam logic [2:0] IO_FLAG = 3'h7;
    // Flag byte and status byte bit positions.
    localparam int FLAG_BUSY = 0;
    localparam int FLAG_OK = 1;
    localparam int FLAG_ERR = 2;
    localparam int ST_EQ = 7;
    localparam int ST_GT = 6;
    localparam int ST_LT = 5;
    // Error codes in the low three status bits.
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_DIVZ = 3'h1;
    localparam logic [2:0] ERR_DOMAIN = 3'h2;
    localparam logic [2:0] ERR_OVF = 3'h3;
    localparam logic [2:0] ERR_UNF = 3'h4;
    localparam logic [2:0] ERR_ARG1 = 3'h5;
    localparam logic [2:0] ERR_ARG2 = 3'h6;
    // Operation codes.
    localparam logic [3:0] fixed_multiply_op = 4'h0;
    localparam logic [3:0] fixed_divide_op = 4'h1;
    localparam logic [3:0] float_multiply_op = 4'h2;
    localparam logic [3:0] float_divide_op = 4'h3;
    localparam logic [3:0] float_add_op = 4'h4;
    localparam logic [3:0] float_subtract_op = 4'h5;
    localparam logic [3:0] float_square_op = 4'h6;
    localparam logic [3:0] float_square_root_op = 4'h7;
    localparam logic [3:0] fixed_to_float_op = 4'h8;
    localparam logic [3:0] float_to_fixed_op = 4'h9;
    localparam logic [3:0] float_compare_op = 4'ha;
    localparam logic [3:0] float_zero_test_op = 4'hb;
    localparam logic [3:0] extended_fixed_divide_op = 4'he;
    localparam logic [3:0] exchange_op = 4'hf;
    // Exponent limits and the wraparound offset.
    localparam logic [9:0] EXP_WRAP = 10'h0be;
    localparam logic signed [9:0] EXP_MAX = 10'sh0fe;
    localparam logic signed [9:0] EXP_MIN = 10'sh001;
    localparam logic [7:0] EXP_RSVD = 8'hff;
    localparam logic [3:0] WIN_ZERO = 4'h0;
    localparam int WIN_DEPTH = 16;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] data;
    } mu_io_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] data;
    } mu_mem_s;

    // Answer of the arithmetic engine; exp is the biased exponent before
    // any range check, as a signed number.
    typedef struct packed {
        logic done;
        logic zero;
        logic fix_ovf;
        logic [9:0] exp;
        logic [31:0] value;
    } mu_eng_s;

    typedef struct packed {
        logic [2:0] err;
        logic eq;
        logic gt;
        logic lt;
        logic use_eng;
        logic exch;
    } mu_chk_s;

    // Only all-zero encodes zero; zero exponent with any other bit set, or
    // the reserved all-ones exponent, is not a legal float.
    function automatic logic float_invalid(input logic [31:0] v);
        float_invalid = (v[30:23] == 8'h00 && v != 32'h0000_0000) ||
                        (v[30:23] == EXP_RSVD);
    endfunction
endpackage

// ===== mu_arg_check.sv
// Argument screening and compare relation of the math unit.
module mu_arg_check (
    input wire logic [3:0] op,
    input wire logic [31:0] arg_a,
    input wire logic [31:0] arg_b,
    output mu_pkg::mu_chk_s chk
);
    logic a_bad;
    logic b_bad;
    logic one_arg_float;
    logic two_arg_float;
    logic is_rel;
    logic fix_div;
    logic [31:0] rhs;
    logic same_pos_gt;
    logic same_neg_gt;
    logic rel_gt;
    logic rel_eq;
    logic [2:0] err;

    // Operand class decode.
    assign a_bad = mu_pkg::float_invalid(arg_a);
    assign b_bad = mu_pkg::float_invalid(arg_b);
    assign two_arg_float = op == mu_pkg::float_add_op ||
        op == mu_pkg::float_subtract_op ||
        op == mu_pkg::float_multiply_op ||
        op == mu_pkg::float_divide_op ||
        op == mu_pkg::float_compare_op;
    assign one_arg_float = two_arg_float ||
        op == mu_pkg::float_square_op ||
        op == mu_pkg::float_square_root_op ||
        op == mu_pkg::float_to_fixed_op ||
        op == mu_pkg::float_zero_test_op;
    assign is_rel = op == mu_pkg::float_compare_op ||
        op == mu_pkg::float_zero_test_op;
    assign fix_div = op == mu_pkg::fixed_divide_op ||
        op == mu_pkg::extended_fixed_divide_op;

    // First argument is screened before the second; a bad first one hides
    // the second altogether.
    assign err = (one_arg_float && a_bad) ? mu_pkg::ERR_ARG1 :
        (two_arg_float && b_bad) ? mu_pkg::ERR_ARG2 :
        (op == mu_pkg::float_divide_op && arg_b == 32'h0) ?
            mu_pkg::ERR_DIVZ :
        (fix_div && arg_b[15:0] == 16'h0) ? mu_pkg::ERR_DIVZ :
        (op == mu_pkg::float_square_root_op && arg_a[31]) ?
            mu_pkg::ERR_DOMAIN :
        mu_pkg::ERR_NONE;

    // Sign-magnitude compare; zero has one encoding so signs decide alone.
    assign rhs = (op == mu_pkg::float_zero_test_op) ? 32'h0 : arg_b;
    assign rel_eq = arg_a == rhs;
    assign same_pos_gt = !arg_a[31] && !rhs[31] && arg_a[30:0] > rhs[30:0];
    assign same_neg_gt = arg_a[31] && rhs[31] && arg_a[30:0] < rhs[30:0];
    assign rel_gt = (!arg_a[31] && rhs[31]) || same_pos_gt || same_neg_gt;

    // Relation bits only when a compare or test ran cleanly.
    assign chk.err = err;
    assign chk.eq = is_rel && err == mu_pkg::ERR_NONE && rel_eq;
    assign chk.gt = is_rel && err == mu_pkg::ERR_NONE && rel_gt;
    assign chk.lt = is_rel && err == mu_pkg::ERR_NONE &&
        !rel_eq && !rel_gt;
    assign chk.exch = op == mu_pkg::exchange_op;
    assign chk.use_eng = err == mu_pkg::ERR_NONE && !is_rel && !chk.exch;
endmodule

// ===== mu_eng_model.sv
// Behavioural arithmetic engine that answers the status unit.
module mu_eng_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic eng_start,
    input wire logic [3:0] eng_op,
    input wire logic [9:0] exp_cfg,
    input wire logic [31:0] val_cfg,
    input wire logic ovf_cfg,
    input wire logic [7:0] dly,
    output mu_pkg::mu_eng_s eng,
    output logic [3:0] last_op
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    logic done_w;
    // Count down from launch; dly must be at least one, since a count loaded
    // as zero never reaches the answer value of one and no answer comes.
    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= 8'h00;
            last_op <= 4'h0;
        end else if (eng_start) begin
            cnt_q <= dly;
            last_op <= eng_op;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
    // Outside the answer cycle the fields carry the inverse, not stale data.
    assign done_w = (cnt_q == 8'h01);
    assign eng = done_w ? {1'b1, 1'b0, ovf_cfg, exp_cfg, val_cfg}
                        : {1'b0, 1'b1, !ovf_cfg, ~exp_cfg, ~val_cfg};
endmodule

// ===== mu_status_unit_tb.sv
// Self-checking bench of the math unit status logic.
module mu_status_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] base = 16'hfff0;
    localparam logic [3:0] a1_ops [9] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                                          4'h7, 4'h9, 4'ha, 4'hb};
    localparam logic [3:0] a2_ops [5] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'ha};
    localparam logic [9:0] w_exp [5] = '{10'h12c, 10'h0ff, 10'h0fe,
                                         10'h000, 10'h3f6};
    localparam logic [31:0] w_res [5] = '{32'h3740_0000, 32'h20c0_0000,
        32'h7f40_0000, 32'h5f40_0000, 32'h5a40_0000};
    localparam logic [7:0] w_st [5] = '{8'h03, 8'h03, 8'h00, 8'h04, 8'h04};
    localparam logic [31:0] c_a [6] = '{32'h3f80_0000, 32'h4000_0000,
        32'h3f80_0000, 32'h0, 32'hbf80_0000, 32'h3f80_0000};
    localparam logic [31:0] c_b [3] = '{32'h3f80_0000, 32'h3f80_0000,
                                        32'h4000_0000};
    localparam logic [7:0] c_st [6] = '{8'h80, 8'h40, 8'h20, 8'h80, 8'h20,
                                        8'h40};
    logic clk = 1'b0;
    logic rst = 1'b1;
    mu_pkg::mu_io_s io = '0;
    mu_pkg::mu_mem_s mem = '0;
    mu_pkg::mu_eng_s eng;
    logic [7:0] io_rdata, mem_rdata, dly = 8'h03;
    logic mem_ack, eng_start, done_ok, done_err, ack, ovf_cfg = 1'b0;
    logic [3:0] eng_op, last_op;
    logic [31:0] eng_a, eng_b, val_cfg = 32'h3fc0_0000;
    logic [9:0] exp_cfg = 10'h080;
    int error_cnt = 0, checks = 0, n_ok = 0, n_err = 0, cyc = 0;

    mu_status_unit mu_status_unit_i (.clk(clk), .rst(rst), .io(io),
        .io_rdata(io_rdata), .mem(mem), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .eng(eng), .eng_start(eng_start),
        .eng_op(eng_op), .eng_a(eng_a), .eng_b(eng_b),
        .done_ok(done_ok), .done_err(done_err));
    mu_eng_model mu_eng_model_i (.clk(clk), .rst(rst),
        .eng_start(eng_start), .eng_op(eng_op), .exp_cfg(exp_cfg),
        .val_cfg(val_cfg), .ovf_cfg(ovf_cfg), .dly(dly), .eng(eng),
        .last_op(last_op));

    always #5 clk = ~clk;
    // Pulses are counted here so that a doubled completion shows up.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (done_ok) n_ok <= n_ok + 1;
        if (done_err) n_err <= n_err + 1;
        if (cyc == 40000) begin
            error_cnt = error_cnt + 1;
            summarize();
        end
    end

    task automatic summarize();
        $display("Checks %0d, errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want) begin
            error_cnt++;
            $display("Error at %0t: got %h want %h", $time, got, want);
        end
    endtask
    // Host strobes are held for one full cycle and dropped at the next fall.
    task automatic io_wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        io <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(negedge clk);
        io <= '0;
    endtask
    task automatic io_rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk);
        io <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(negedge clk);
        d = io_rdata;
        io <= '0;
    endtask
    task automatic mem_op(input logic w, input logic [15:0] a,
                          input logic [7:0] di, output logic [7:0] dq);
        @(negedge clk);
        mem <= '{wr: w, rd: !w, addr: a, data: di};
        @(negedge clk);
        dq = mem_rdata;
        ack = mem_ack;
        mem <= '0;
    endtask
    task automatic put32(input logic [15:0] a, input logic [31:0] v);
        logic [7:0] d;
        for (int i = 0; i < 4; i++) mem_op(1'b1, a + 16'(i), v[8*i +: 8], d);
    endtask
    task automatic get32(input logic [15:0] a, output logic [31:0] v);
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            mem_op(1'b0, a + 16'(i), 8'h00, d);
            v[8*i +: 8] = d;
        end
    endtask
    // Start an operation, poll busy, then judge status, flag and pulses.
    task automatic run(input logic [3:0] op, input logic [7:0] st,
                       input logic probe);
        logic [7:0] f;
        int ok0, er0;
        ok0 = n_ok;
        er0 = n_err;
        io_wr(mu_pkg::IO_OPCODE, {4'h0, op});
        if (probe) begin
            io_rd(mu_pkg::IO_FLAG, f);
            chk(f, 8'h01);
            io_rd(mu_pkg::IO_STATUS, f);
            chk(f, 8'h00);
            io_wr(mu_pkg::IO_MEM_LOW, 8'h00);
            io_wr(mu_pkg::IO_MEM_HIGH, 8'h10);
            mem_op(1'b1, base, 8'h00, f);
            chk(ack, 1'b0);
        end
        f = 8'h01;
        for (int i = 0; i < 300 && f[0] !== 1'b0; i++) begin
            io_rd(mu_pkg::IO_FLAG, f);
        end
        io_rd(mu_pkg::IO_STATUS, f);
        chk(f, st);
        chk(n_ok - ok0, st[2:0] == 3'h0);
        chk(n_err - er0, st[2:0] != 3'h0);
        io_rd(mu_pkg::IO_FLAG, f);
        chk(f, (st[2:0] == 3'h0) ? 8'h02 : 8'h04);
    endtask
    task automatic op_case(input logic [3:0] op, input logic [31:0] a1,
        input logic [31:0] a2, input logic [7:0] st, input logic ck,
        input logic [31:0] r1);
        logic [31:0] r;
        put32(base, a1);
        put32(base + 16'h0004, a2);
        run(op, st, 1'b0);
        get32(base, r);
        if (ck) chk(r, r1);
    endtask

    // The window stays silent until the high base byte is written.
    task automatic t_base();
        logic [7:0] d;
        io_rd(mu_pkg::IO_FLAG, d);
        chk(d, 8'h00);
        mem_op(1'b1, base + 16'h0009, 8'h5a, d);
        chk(ack, 1'b0);
        io_wr(mu_pkg::IO_MEM_LOW, 8'hf0);
        io_wr(mu_pkg::IO_MEM_HIGH, 8'hff);
        mem_op(1'b1, base + 16'h0009, 8'h5a, d);
        mem_op(1'b0, base + 16'h0009, 8'h00, d);
        chk({ack, d}, 9'h15a);
        mem_op(1'b0, base - 16'h0010, 8'h00, d);
        chk(ack, 1'b0);
    endtask
    // A long operation is probed while busy; the old base must survive.
    task automatic t_busy();
        logic [31:0] r;
        dly = 8'd40;
        val_cfg = 32'h4000_0000;
        put32(base, 32'h3f80_0000);
        put32(base + 16'h0004, 32'h3f80_0000);
        run(4'h4, 8'h00, 1'b1);
        get32(base, r);
        chk(r, 32'h4000_0000);
        chk(eng_a, 32'h3f80_0000);
        chk(eng_b, 32'h3f80_0000);
        chk(last_op, 4'h4);
        dly = 8'h03;
        val_cfg = 32'h3fc0_0000;
    endtask
    task automatic t_divz();
        op_case(4'h1, 32'h64, 32'h1234_0000, 8'h01, 1'b0, 32'h0);
        op_case(4'he, 32'h64, 32'h1234_0000, 8'h01, 1'b0, 32'h0);
        op_case(4'h3, 32'h3f80_0000, 32'h0, 8'h01, 1'b0, 32'h0);
        op_case(4'h7, 32'hbf80_0000, 32'h0, 8'h02, 1'b0, 32'h0);
        // Integer and conversion results pass through without wraparound.
        op_case(4'h0, 32'h64, 32'h2, 8'h00, 1'b1, 32'h3fc0_0000);
        op_case(4'h8, 32'h64, 32'h0, 8'h00, 1'b1, 32'h3fc0_0000);
    endtask
    task automatic t_args();
        logic [31:0] a;
        for (int i = 0; i < 9; i++) begin
            a = i[0] ? 32'h7f80_0001 : 32'h0040_0000;
            op_case(a1_ops[i], a, 32'h1, 8'h05, 1'b1, a);
        end
        for (int i = 0; i < 5; i++) begin
            op_case(a2_ops[i], 32'h3f80_0000, 32'h7f80_0000, 8'h06, 1'b0,
                    32'h0);
            get32(base + 16'h0004, a);
            chk(a, 32'h7f80_0000);
        end
    endtask
    // Exponent over, edge, in range, zero and negative across float ops.
    task automatic t_wrap();
        for (int i = 0; i < 5; i++) begin
            exp_cfg = w_exp[i];
            op_case(4'(i + 2), 32'h3f80_0000, 32'h3f80_0000, w_st[i], 1'b1,
                    w_res[i]);
        end
        exp_cfg = 10'h080;
        ovf_cfg = 1'b1;
        op_case(4'h9, 32'h4f80_0000, 32'h0, 8'h03, 1'b1,
                32'h4f80_0000);
        ovf_cfg = 1'b0;
    endtask
    task automatic t_cmp();
        for (int i = 0; i < 6; i++) begin
            op_case((i < 3) ? 4'ha : 4'hb, c_a[i], (i < 3) ? c_b[i] : 32'h0,
                    c_st[i], 1'b0, 32'h0);
        end
        op_case(4'hf, 32'h1111_1111, 32'h2222_2222, 8'h00, 1'b1,
                32'h2222_2222);
    endtask

    initial begin
        repeat (5) @(negedge clk);
        rst <= 1'b0;
        t_base();
        t_busy();
        t_divz();
        t_args();
        t_wrap();
        t_cmp();
        summarize();
    end
endmodule
